// ---- hw/safh_top.sv ----
/*
 Servo axis: law selection, rates, homing search, periodic update.
 Assumes synchronous inputs and one 20 MHz clock.
*/
`include "safh_cfg.svh"
module safh_top
	import safh_pkg::*;
#(
	parameter int UPDATE_CYCLES = `SAFH_UPDATE_CYCLES
) (
	input  wire logic               clk_sys,      // System clock
	input  wire logic               rst_n,        // Async reset, low
	input  wire logic               ce,           // Clock enable
	input  wire logic               sel_wr,       // Filter select write
	input  wire logic [2:0]         sel_val,      // Filter select value
	input  wire logic               prof_wr,      // Profile command
	input  wire logic [15:0]        prof_speed,   // Max speed, steps/s
	input  wire logic [31:0]        prof_accel,   // Accel, steps/s2
	input  wire logic [7:0]         prof_kp,      // Proportional gain
	input  wire logic [7:0]         prof_ki,      // Integral gain
	input  wire logic [7:0]         prof_kd,      // Derivative gain
	input  wire logic               vff_wr,       // Velocity ff write
	input  wire logic               aff_wr,       // Accel ff write
	input  wire logic [15:0]        gain_val,     // Gain write data
	input  wire logic               decel_wr,     // Decel write
	input  wire logic [31:0]        decel_val,    // Decel value
	input  wire logic               hdir_wr,      // Homing dir write
	input  wire logic signed [15:0] hdir_val,     // Homing dir value
	input  wire logic               home_start,   // Search and zero
	input  wire logic               home_in,      // Home input, high on
	input  wire logic               index_in,     // Index marker
	input  wire logic               index_conn,   // Index connected
	input  wire logic               at_rest,      // Ramp reached zero
	input  wire logic signed [15:0] pos_err,      // Position error
	input  wire logic signed [15:0] vel,          // Current velocity
	output safh_pkg::safh_law_type  law,          // Active law
	output logic signed [15:0]      cmd,          // Analog command
	output logic                    update,       // Update strobe
	output logic [31:0]             accel_rate,   // Acceleration rate
	output logic [31:0]             decel_rate,   // Deceleration rate
	output logic [15:0]             move_speed,   // Speed request
	output logic                    move_cw,      // Move clockwise
	output logic                    move_run,     // Motion requested
	output logic                    hard_stop,    // Hard stop pulse
	output logic                    pos_clear,    // Clear position pulse
	output logic                    home_busy,    // Homing in progress
	output logic                    home_done     // Homing complete
);
	import safh_pkg::*;

	logic [2:0]         sel;
	logic               profiled;
	logic [7:0]         kp;
	logic [15:0]        kvff;
	logic [15:0]        kaff;
	logic               hrev;
	logic [15:0]        max_speed;
	logic [15:0]        tick;
	logic               calc;
	logic signed [15:0] last_vel;
	logic signed [15:0] dvel;
	logic               home_q;
	safh_home_type      hs;

	// Selection only sticks before the first profile
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			sel <= 3'h0;
		else if (ce && sel_wr && !profiled)
			sel <= sel_val;
	end

	// Law is latched by the profile, so direct mode waits for it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			profiled <= 1'b0;
			law      <= SAFH_LAW_THREE;
		end else if (ce && prof_wr) begin
			profiled <= 1'b1;
			if (sel == `SAFH_SEL_FF)
				law <= SAFH_LAW_FF;
			else if (sel == `SAFH_SEL_DIR_CCW || sel == `SAFH_SEL_DIR_CW)
				law <= SAFH_LAW_DIRECT;
			else
				law <= SAFH_LAW_THREE;
		end
	end

	// Integral and derivative gains are not stored: no law here uses them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kp        <= 8'h00;
			max_speed <= 16'h0000;
		end else if (ce && prof_wr) begin
			kp        <= prof_kp;
			max_speed <= prof_speed;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kvff <= 16'h0000;
			kaff <= 16'h0000;
		end else if (ce) begin
			if (vff_wr)
				kvff <= gain_val;
			if (aff_wr)
				kaff <= gain_val;
		end
	end

	// A profile in the same cycle as a decel write wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_rate <= 32'h0;
			decel_rate <= 32'h0;
		end else if (ce) begin
			if (prof_wr) begin
				accel_rate <= prof_accel;
				decel_rate <= prof_accel;
			end else if (decel_wr)
				decel_rate <= decel_val;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			hrev <= 1'b0;
		else if (ce && hdir_wr)
			hrev <= (hdir_val == 16'sd1);
	end

	// Update timer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 16'h0000;
			calc <= 1'b0;
		end else if (ce) begin
			calc <= (tick == 16'(UPDATE_CYCLES - 1));
			if (tick == 16'(UPDATE_CYCLES - 1))
				tick <= 16'h0000;
			else
				tick <= tick + 16'h0001;
		end
	end

	// Change is taken at the update that uses it, not one period late
	always_comb begin
		dvel = vel - last_vel;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			update   <= 1'b0;
			last_vel <= 16'sh0000;
		end else if (ce) begin
			update <= calc;
			if (calc)
				last_vel <= vel;
		end
	end

	safh_law u_law (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.calc    (calc),
		.law     (law),
		.dir_cw  (sel == `SAFH_SEL_DIR_CW),
		.pos_err (pos_err),
		.dvel    (dvel),
		.vel     (vel),
		.kp      (kp),
		.kaff    (kaff),
		.kvff    (kvff),
		.cmd     (cmd)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			home_q <= 1'b0;
		else if (ce)
			home_q <= home_in;
	end

	// Homing search
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hs         <= SAFH_H_IDLE;
			move_speed <= 16'h0000;
			move_cw    <= 1'b0;
			move_run   <= 1'b0;
			hard_stop  <= 1'b0;
			pos_clear  <= 1'b0;
			home_done  <= 1'b0;
		end else if (ce) begin
			hard_stop <= 1'b0;
			pos_clear <= 1'b0;
			unique case (hs)
			SAFH_H_IDLE, SAFH_H_DONE: begin
				if (home_start) begin
					hs         <= SAFH_H_SEEK;
					move_speed <= max_speed;
					move_cw    <= hrev;
					move_run   <= 1'b1;
					home_done  <= 1'b0;
				end
			end
			SAFH_H_SEEK: begin
				if (home_in && !home_q) begin
					hs       <= SAFH_H_STOP1;
					move_run <= 1'b0;
				end
			end
			SAFH_H_STOP1: begin
				if (at_rest) begin
					hs         <= SAFH_H_FAST;
					move_speed <= `SAFH_HOME_FAST_SPS;
					move_cw    <= !hrev;
					move_run   <= 1'b1;
				end
			end
			SAFH_H_FAST: begin
				if (home_in && !home_q) begin
					hs         <= SAFH_H_SLOW;
					move_speed <= `SAFH_HOME_SLOW_SPS;
				end
			end
			SAFH_H_SLOW: begin
				if (!home_in && home_q) begin
					move_run  <= 1'b0;
					hard_stop <= 1'b1;
					hs        <= SAFH_H_HALT;
				end
			end
			SAFH_H_HALT: begin
				if (index_conn) begin
					hs         <= SAFH_H_INDEX;
					move_speed <= `SAFH_HOME_SLOW_SPS;
					move_cw    <= hrev;
					move_run   <= 1'b1;
				end else begin
					pos_clear <= 1'b1;
					home_done <= 1'b1;
					hs        <= SAFH_H_DONE;
				end
			end
			SAFH_H_INDEX: begin
				if (index_in) begin
					move_run  <= 1'b0;
					hard_stop <= 1'b1;
					pos_clear <= 1'b1;
					home_done <= 1'b1;
					hs        <= SAFH_H_DONE;
				end
			end
			default: hs <= SAFH_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			home_busy <= 1'b0;
		else if (ce)
			home_busy <= !(hs == SAFH_H_IDLE || hs == SAFH_H_DONE);
	end

	property p_ff_sel;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && prof_wr && sel == `SAFH_SEL_FF) |=> law == SAFH_LAW_FF;
	endproperty
	a_ff_sel: assert property (p_ff_sel) else $error("ff law not taken");

	property p_rates;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && prof_wr) |=> (accel_rate == decel_rate);
	endproperty
	a_rates: assert property (p_rates) else $error("rates differ");

	property p_decel;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && decel_wr && !prof_wr) |=> decel_rate == $past(decel_val);
	endproperty
	a_decel: assert property (p_decel) else $error("decel lost");

	property p_tick;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && calc) |=> !calc;
	endproperty
	a_tick: assert property (p_tick) else $error("update too fast");

	sequence s_slow;
		ce && hs == SAFH_H_FAST && home_in && !home_q;
	endsequence
	property p_slow;
		@(posedge clk_sys) disable iff (!rst_n)
		s_slow |=> move_speed == `SAFH_HOME_SLOW_SPS;
	endproperty
	a_slow: assert property (p_slow) else $error("no slow speed");

	property p_fast;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && hs == SAFH_H_STOP1 && at_rest)
			|=> move_speed == `SAFH_HOME_FAST_SPS && move_cw != hrev;
	endproperty
	a_fast: assert property (p_fast) else $error("bad fast stage");

	property p_release;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && hs == SAFH_H_SLOW && !home_in && home_q)
			|=> hard_stop && !move_run;
	endproperty
	a_release: assert property (p_release) else $error("no hard stop");

	property p_index;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && hs == SAFH_H_INDEX && index_in) |=> pos_clear && home_done;
	endproperty
	a_index: assert property (p_index) else $error("index not zeroed");
endmodule // safh_top

// ---- hw/safh_cfg.svh ----
/*
 Constants for the servo axis filter and homing block.
 Assumes a 20 MHz system clock; included by every design file except the package.
*/
`ifndef SAFH_CFG_SVH
`define SAFH_CFG_SVH
`define SAFH_CLK_HZ          20000000
`define SAFH_UPDATE_HZ       2048
`define SAFH_UPDATE_CYCLES   (`SAFH_CLK_HZ / `SAFH_UPDATE_HZ)
`define SAFH_SEL_FF          3'h5
`define SAFH_SEL_DIR_CCW     3'h1
`define SAFH_SEL_DIR_CW      3'h2
`define SAFH_HOME_FAST_SPS   16'h03b6
`define SAFH_HOME_SLOW_SPS   16'h00c0
`define SAFH_DIRECT_MAX      16'h7fff
`define SAFH_CMD_W           16
`define SAFH_CMD_FULL        16'h7fff
`endif

// ---- hw/safh_pkg.sv ----
/*
 Types for the servo axis filter and homing block.
 Assumes safh_cfg.svh is available on the include path.
*/
package safh_pkg;
	typedef enum logic [2:0] {
		SAFH_LAW_THREE   = 3'b001,
		SAFH_LAW_FF      = 3'b010,
		SAFH_LAW_DIRECT  = 3'b100
	} safh_law_type;
	typedef enum logic [7:0] {
		SAFH_H_IDLE  = 8'b00000001,
		SAFH_H_SEEK  = 8'b00000010,
		SAFH_H_STOP1 = 8'b00000100,
		SAFH_H_FAST  = 8'b00001000,
		SAFH_H_SLOW  = 8'b00010000,
		SAFH_H_INDEX = 8'b00100000,
		SAFH_H_DONE  = 8'b01000000,
		SAFH_H_HALT  = 8'b10000000
	} safh_home_type;
endpackage

// ---- hw/safh_law.sv ----
/*
 Command law: feedforward sum, direct output, scaling and clamp.
 Assumes operands are stable while calc is high.
*/
`include "safh_cfg.svh"
module safh_law (
	input  wire logic               clk_sys, // System clock
	input  wire logic               rst_n,   // Async reset, low
	input  wire logic               ce,      // Clock enable
	input  wire logic               calc,    // Update strobe
	input  wire logic [2:0]         law,     // One-hot law
	input  wire logic               dir_cw,  // Direct polarity
	input  wire logic signed [15:0] pos_err, // Position error
	input  wire logic signed [15:0] dvel,    // Velocity change
	input  wire logic signed [15:0] vel,     // Current velocity
	input  wire logic [7:0]         kp,      // Proportional gain
	input  wire logic [15:0]        kaff,    // Accel ff gain
	input  wire logic [15:0]        kvff,    // Velocity ff gain
	output logic signed [15:0]      cmd      // Command output
);
	function automatic logic signed [15:0] sat(input logic signed [47:0] v);
		if (v > 48'sd32767)
			sat = 16'sh7fff;
		else if (v < -48'sd32767)
			sat = -16'sh7fff;
		else
			sat = v[15:0];
	endfunction

	logic signed [47:0] sum;
	logic        [15:0] dmag;
	always_comb begin
		sum = 48'(pos_err * $signed({1'b0, kp}))
			+ 48'(dvel * $signed({1'b0, kaff}))
			+ 48'(vel * $signed({1'b0, kvff}));
		dmag = (kvff > `SAFH_DIRECT_MAX) ? `SAFH_DIRECT_MAX : kvff;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cmd <= 16'sh0000;
		else if (ce && calc) begin
			if (law[2])
				cmd <= dir_cw ? $signed(dmag) : -$signed(dmag);
			else if (law[1])
				cmd <= sat(sum >>> 8);
			else
				cmd <= sat(48'(pos_err * $signed({1'b0, kp})));
		end
	end
endmodule // safh_law

// ---- dv/safh_drive.sv ----
/*
 Behavioural servo drive with encoder, home switch and index marker.
 Assumes one encoder step per clock while the axis moves.
*/
module safh_drive (
	input  wire logic clk_sys,    // System clock
	input  wire logic rst_n,      // Async reset, low
	input  wire logic move_run,   // Motion requested
	input  wire logic move_cw,    // Clockwise
	input  wire logic hard_stop,  // Stop at once
	input  wire logic pos_clear,  // Zero the counter
	input  wire logic index_conn, // Marker wired
	output logic      home_in,    // Home switch, high on
	output logic      index_in,   // Index marker
	output logic      at_rest     // Axis stopped
);
	timeunit 1ns;
	timeprecision 1ns;
	int   pos;
	int   coast;
	logic cw_q;
	// A ramped stop overshoots, so the axis leaves the home zone
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos <= 0;
			coast <= 0;
			cw_q <= 1'b0;
		end else if (pos_clear) begin
			pos <= 0;
			coast <= 0;
		end else if (hard_stop) begin
			coast <= 0;
		end else if (move_run) begin
			pos <= move_cw ? pos + 1 : pos - 1;
			cw_q <= move_cw;
			coast <= 15;
		end else if (coast != 0) begin
			pos <= cw_q ? pos + 1 : pos - 1;
			coast <= coast - 1;
		end
	end
	// Zone mirrored about zero so reversed homing finds it too
	assign home_in = (pos >= 10 && pos <= 20) || (pos <= -10 && pos >= -20);
	assign index_in = index_conn && (pos == 15 || pos == -15);
	assign at_rest = !move_run && coast == 0;
endmodule // safh_drive

// ---- dv/safh_top_tb.sv ----
/*
 Self-checking bench for the servo axis filter and homing block.
 Assumes the drive model safh_drive and a 20 MHz clock.
*/
module safh_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import safh_pkg::*;
	localparam int UPD = 16;
	logic               clk_sys, rst_n, ce, sel_wr, prof_wr, vff_wr;
	logic               aff_wr, decel_wr, hdir_wr, home_start, index_conn;
	logic [2:0]         sel_val;
	logic [15:0]        prof_speed, gain_val, move_speed;
	logic [31:0]        prof_accel, decel_val, accel_rate, decel_rate;
	logic [7:0]         prof_kp, prof_ki, prof_kd;
	logic signed [15:0] hdir_val, pos_err, vel, cmd;
	logic               home_in, index_in, at_rest, update, move_cw;
	logic               move_run, hard_stop, pos_clear, home_busy, home_done;
	safh_law_type       law;
	int                 error_cnt, checks_done, n;

	safh_top #(.UPDATE_CYCLES(UPD)) u_safh_top (.clk_sys, .rst_n, .ce,
		.sel_wr, .sel_val, .prof_wr, .prof_speed, .prof_accel, .prof_kp,
		.prof_ki, .prof_kd, .vff_wr, .aff_wr, .gain_val, .decel_wr,
		.decel_val, .hdir_wr, .hdir_val, .home_start, .home_in, .index_in,
		.index_conn, .at_rest, .pos_err, .vel, .law, .cmd, .update,
		.accel_rate, .decel_rate, .move_speed, .move_cw, .move_run,
		.hard_stop, .pos_clear, .home_busy, .home_done);
	safh_drive u_safh_drive (.clk_sys, .rst_n, .move_run, .move_cw,
		.hard_stop, .pos_clear, .index_conn, .home_in, .index_in, .at_rest);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic tick(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	function automatic logic cond(int k);
		case (k)
			0: return move_speed === 16'h03b6;
			1: return move_speed === 16'h00c0;
			2: return hard_stop === 1'b1;
			3: return pos_clear === 1'b1;
			4: return move_run === 1'b1;
			default: return update === 1'b1;
		endcase
	endfunction

	// Bounded so a stuck stage shows as a mismatch, not a hang
	task automatic wait_c(int k);
		int m;
		m = 0;
		while (!cond(k) && m < 3000) begin
			tick(1);
			m++;
		end
		check("wait", m < 3000, 1'b1);
	endtask

	task automatic next_upd();
		tick(1);
		wait_c(5);
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		tick(1);
	endtask

	task automatic select(logic [2:0] v);
		@(posedge clk_sys);
		sel_wr <= 1'b1;
		sel_val <= v;
		@(posedge clk_sys);
		sel_wr <= 1'b0;
	endtask

	task automatic profile(logic [31:0] acc);
		@(posedge clk_sys);
		prof_wr <= 1'b1;
		prof_accel <= acc;
		@(posedge clk_sys);
		prof_wr <= 1'b0;
		tick(1);
	endtask

	task automatic gains(logic [15:0] v, logic [15:0] a);
		@(posedge clk_sys);
		vff_wr <= 1'b1;
		gain_val <= v;
		@(posedge clk_sys);
		vff_wr <= 1'b0;
		aff_wr <= 1'b1;
		gain_val <= a;
		@(posedge clk_sys);
		aff_wr <= 1'b0;
	endtask

	task automatic t_direct(logic [2:0] s, int sgn);
		do_reset();
		check("law_rst", law, SAFH_LAW_THREE);
		check("cmd_rst", cmd, 0);
		select(s);
		gains(16'd1000, 16'd0);
		tick(2);
		check("law_pre", law, SAFH_LAW_THREE);
		profile(100);
		check("law_dir", law, SAFH_LAW_DIRECT);
		next_upd();
		check("cmd_dir", cmd, sgn * 1000);
		gains(16'h7fff, 16'd0);
		next_upd();
		next_upd();
		check("cmd_full", cmd, sgn * 32767);
	endtask

	task automatic t_ff();
		do_reset();
		select(3'h5);
		gains(16'd16, 16'd256);
		pos_err <= 16'sd100;
		vel <= 16'sd10;
		profile(100);
		check("law_ff", law, SAFH_LAW_FF);
		next_upd();
		n = 0;
		do begin
			tick(1);
			n++;
		end while (update !== 1'b1 && n < 100);
		check("period", n, UPD);
		check("cmd_ff", cmd, 2);
		@(posedge clk_sys);
		vel <= 16'sd266;
		pos_err <= 16'sd0;
		next_upd();
		check("cmd_acc", cmd, 272);
		next_upd();
		check("cmd_vel", cmd, 16);
		gains(16'h7fff, 16'd256);
		vel <= 16'sd32767;
		next_upd();
		next_upd();
		check("cmd_pos", cmd, 32767);
		@(posedge clk_sys);
		vel <= -16'sd32767;
		next_upd();
		next_upd();
		check("cmd_neg", cmd, -32767);
		select(3'h1);
		profile(100);
		check("law_keep", law, SAFH_LAW_FF);
	endtask

	task automatic t_rates();
		do_reset();
		profile(32'd100000);
		check("acc", accel_rate, 32'd100000);
		check("dec", decel_rate, 32'd100000);
		@(posedge clk_sys);
		decel_wr <= 1'b1;
		decel_val <= 32'd20000;
		@(posedge clk_sys);
		decel_wr <= 1'b0;
		tick(1);
		check("dec_own", decel_rate, 32'd20000);
		check("acc_keep", accel_rate, 32'd100000);
		profile(32'd60000);
		check("dec_later", decel_rate, 32'd60000);
		// Profile and decel write on one edge: the profile wins
		@(posedge clk_sys);
		decel_wr <= 1'b1;
		prof_wr <= 1'b1;
		prof_accel <= 32'd50000;
		@(posedge clk_sys);
		decel_wr <= 1'b0;
		prof_wr <= 1'b0;
		tick(1);
		check("dec_over", decel_rate, 32'd50000);
		@(posedge clk_sys);
		ce <= 1'b0;
		profile(32'd777);
		check("frozen", accel_rate, 32'd50000);
		check("frozen_dec", decel_rate, 32'd50000);
		@(posedge clk_sys);
		ce <= 1'b1;
	endtask

	task automatic t_home(logic signed [15:0] hd, logic conn);
		logic rev;
		rev = (hd == 16'sd1);
		do_reset();
		@(posedge clk_sys);
		index_conn <= conn;
		profile(100);
		@(posedge clk_sys);
		hdir_wr <= 1'b1;
		hdir_val <= hd;
		@(posedge clk_sys);
		hdir_wr <= 1'b0;
		home_start <= 1'b1;
		@(posedge clk_sys);
		home_start <= 1'b0;
		tick(1);
		check("seek_run", move_run, 1'b1);
		check("seek_cw", move_cw, rev);
		check("seek_spd", move_speed, 16'h1234);
		wait_c(0);
		check("fast_cw", move_cw, !rev);
		check("busy", home_busy, 1'b1);
		wait_c(1);
		check("slow_cw", move_cw, !rev);
		wait_c(2);
		check("hs_run", move_run, 1'b0);
		if (conn) begin
			wait_c(4);
			check("idx_cw", move_cw, rev);
			check("idx_spd", move_speed, 16'h00c0);
			wait_c(3);
			check("idx_hs", hard_stop, 1'b1);
		end else begin
			wait_c(3);
		end
		check("done", home_done, 1'b1);
		tick(1);
		check("idle", home_busy, 1'b0);
	endtask

	initial begin
		{sel_wr, prof_wr, vff_wr, aff_wr, decel_wr, hdir_wr} = '0;
		{home_start, index_conn, sel_val, gain_val} = '0;
		{decel_val, hdir_val, pos_err, vel, prof_accel} = '0;
		rst_n = 1'b0;
		ce = 1'b1;
		prof_speed = 16'h1234;
		prof_kp = 8'h04;
		prof_ki = 8'hc8;
		prof_kd = 8'hc8;
		error_cnt = 0;
		checks_done = 0;
		t_direct(3'h2, 1);
		t_direct(3'h1, -1);
		t_ff();
		t_rates();
		t_home(16'sd0, 1'b1);
		t_home(16'sd1, 1'b1);
		t_home(-16'sd1, 1'b0);
		stop_test();
	end

	// Whole run needs well under a tenth of this span
	initial begin
		#2ms;
		error_cnt++;
		stop_test();
	end
endmodule // safh_top_tb
